// ==== rtl/stepper_status_pkg.sv ====
// Constants, register map and peak-level table for the stepper driver status bank
// Functional notes
// - Five-bit peak level sets coil amplitude; 00000 smallest, rising to 11111 at 3015 mA.
// - Exactly four read-only status registers, all bits zero after hard reset.
// - Register 04h live: check, thermal alert, pump fault, watchdog, coil X, coil Y.
// - Register 05h latched: check bit, X overloads PT, PB, NT, NB in bits 6:3.
// - Register 06h latched: check bit, Y overloads bits 6:3, thermal trip bit 2.
// - Register 07h live: check bit and seven-bit micro-step position.
// - Pump fault reads one while charge pump is below level, else zero.
// - Step position is seven bits from the translator, reset to zero.
// - Each coil break flag reads one while an open coil is seen on its bridge.
// - Each of eight overload flags reports overcurrent at its own transistor.
// - Watchdog event flag sets when a watchdog time-out has caused a reset.
// - Watchdog flag clears only when master writes zero to the enable bit.
// - Watchdog enable is bit 7 of read-write register 00h, reset to zero.
`default_nettype none

package stepper_status_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_WDOG = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_CTRL0 = 8'h01;
    localparam logic [ADDR_W-1:0] ADDR_LIVE_FAULT = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_X_LATCH = 8'h05;
    localparam logic [ADDR_W-1:0] ADDR_Y_LATCH = 8'h06;
    localparam logic [ADDR_W-1:0] ADDR_STEP_POS = 8'h07;
    localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int CHECK_BIT = 7;
    localparam int WATCHDOG_ENABLE_BIT_BIT = 7;
    localparam int WDT_LSB = 3;
    localparam int WDT_W = 4;
    localparam int MODE_LSB = 5;
    localparam int MODE_W = 3;
    localparam int LEVEL_LSB = 0;
    localparam int LEVEL_W = 5;
    localparam int POS_W = 7;
    localparam int OVL_W = 4;
    localparam int MA_W = 12;

    // ------------------------------------------------------------
    // Synchroniser lanes for fault pins
    // ------------------------------------------------------------
    localparam int SY_ALERT = 0;
    localparam int SY_PUMP = 1;
    localparam int SY_XBRK = 2;
    localparam int SY_YBRK = 3;
    localparam int SY_TRIP = 4;
    localparam int SY_XOVL = 5;
    localparam int SY_YOVL = 9;
    localparam int SYNC_W = 13;

    // ------------------------------------------------------------
    // Typical peak amplitude in mA, index 31 first
    // ------------------------------------------------------------
    localparam logic [31:0][MA_W-1:0] PEAK_MA_TABLE = {
        12'hBC7, 12'hAD7, 12'h9F8, 12'h94A, 12'h869, 12'h79E, 12'h6E7, 12'h659,
        12'h5CD, 12'h4E7, 12'h4A5, 12'h435, 12'h3CF, 12'h373, 12'h320, 12'h2DF,
        12'h28E, 12'h252, 12'h21A, 12'h1E8, 12'h1BA, 12'h190, 12'h16E, 12'h148,
        12'h129, 12'h10D, 12'h0F4, 12'h0DD, 12'h0C8, 12'h0BD, 12'h087, 12'h042
    };

endpackage : stepper_status_pkg

`default_nettype wire

// ==== rtl/fault_pin_sync.sv ====
// Two-stage synchroniser for the asynchronous fault pins
`default_nettype none

module fault_pin_sync #(
    parameter int WIDTH = stepper_status_pkg::SYNC_W
) (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t sync_q;
    sync_state_t sync_d;

    // Only the second stage is visible outside
    always_comb begin
        sync_d = sync_q;
        sync_d.meta = i_async;
        sync_d.stable = sync_q.meta;
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            sync_q <= '0;
        end else begin
            sync_q <= sync_d;
        end
    end

    assign o_sync = sync_q.stable;

endmodule : fault_pin_sync

`default_nettype wire

// ==== rtl/stepper_driver_status_regs.sv ====
// Status bank, watchdog flag and peak-level setting of the stepper driver
`default_nettype none

module stepper_driver_status_regs (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [stepper_status_pkg::ADDR_W-1:0] i_reg_addr,
    input wire logic [stepper_status_pkg::DATA_W-1:0] i_reg_wdata,
    input wire logic i_thermal_alert,
    input wire logic i_thermal_trip,
    input wire logic i_pump_fault,
    input wire logic i_coil_x_break,
    input wire logic i_coil_y_break,
    input wire logic i_x_pos_high_side_overload,
    input wire logic i_x_pos_low_side_overload,
    input wire logic i_x_neg_high_side_overload,
    input wire logic i_x_neg_low_side_overload,
    input wire logic i_y_pos_high_side_overload,
    input wire logic i_y_pos_low_side_overload,
    input wire logic i_y_neg_high_side_overload,
    input wire logic i_y_neg_low_side_overload,
    input wire logic i_watchdog_timeout,
    input wire logic [stepper_status_pkg::POS_W-1:0] i_step_position,
    output logic [stepper_status_pkg::DATA_W-1:0] o_reg_rdata,
    output logic o_reg_rvalid,
    output logic [stepper_status_pkg::LEVEL_W-1:0] o_coil_peak_level,
    output logic [stepper_status_pkg::MA_W-1:0] o_peak_coil_amplitude,
    output logic o_watchdog_enable_bit,
    output logic [stepper_status_pkg::WDT_W-1:0] o_watchdog_time,
    output logic [stepper_status_pkg::MODE_W-1:0] o_step_mode,
    output logic o_watchdog_event_flag
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic wd_enable;
        logic [stepper_status_pkg::WDT_W-1:0] wd_time;
        logic [stepper_status_pkg::MODE_W-1:0] step_mode;
        logic [stepper_status_pkg::LEVEL_W-1:0] coil_level;
        logic [stepper_status_pkg::MA_W-1:0] peak_ma;
        logic wd_event;
        logic [stepper_status_pkg::OVL_W-1:0] x_latch;
        logic [stepper_status_pkg::OVL_W:0] y_latch;
        logic [stepper_status_pkg::DATA_W-1:0] rdata;
        logic rvalid;
        logic [stepper_status_pkg::ADDR_W-1:0] rd_addr;
    } regs_state_t;

    regs_state_t regs_q;
    regs_state_t regs_d;

    logic [stepper_status_pkg::SYNC_W-1:0] pins_async;
    logic [stepper_status_pkg::SYNC_W-1:0] pins_sync;
    logic [stepper_status_pkg::OVL_W-1:0] x_ovl;
    logic [stepper_status_pkg::OVL_W-1:0] y_ovl;
    logic [stepper_status_pkg::DATA_W-1:0] live_fault_status;
    logic [stepper_status_pkg::DATA_W-1:0] x_bridge_fault_latch;
    logic [stepper_status_pkg::DATA_W-1:0] y_bridge_thermal_latch;
    logic [stepper_status_pkg::DATA_W-1:0] step_position_status;
    logic [stepper_status_pkg::DATA_W-1:0] read_mux;
    logic wdog_write;
    logic wd_clear;

    // ------------------------------------------------------------
    // Fault pins into the clock domain
    // ------------------------------------------------------------
    // Lane order follows the SY_ index constants
    assign pins_async = {i_y_pos_high_side_overload, i_y_pos_low_side_overload,
                         i_y_neg_high_side_overload, i_y_neg_low_side_overload,
                         i_x_pos_high_side_overload, i_x_pos_low_side_overload,
                         i_x_neg_high_side_overload, i_x_neg_low_side_overload,
                         i_thermal_trip, i_coil_y_break, i_coil_x_break,
                         i_pump_fault, i_thermal_alert};

    fault_pin_sync #(
        .WIDTH(stepper_status_pkg::SYNC_W)
    ) u_fault_pin_sync (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_async(pins_async),
        .o_sync(pins_sync)
    );

    assign x_ovl = pins_sync[stepper_status_pkg::SY_XOVL +: stepper_status_pkg::OVL_W];
    assign y_ovl = pins_sync[stepper_status_pkg::SY_YOVL +: stepper_status_pkg::OVL_W];

    // ------------------------------------------------------------
    // Status register images
    // ------------------------------------------------------------
    function automatic logic [stepper_status_pkg::DATA_W-1:0] with_check(
        input logic [stepper_status_pkg::DATA_W-2:0] payload
    );
        // Even parity: all-zero image keeps its zero reset value
        with_check = {^payload, payload};
    endfunction : with_check

    always_comb begin
        live_fault_status = with_check({pins_sync[stepper_status_pkg::SY_ALERT],
                                        pins_sync[stepper_status_pkg::SY_PUMP],
                                        regs_q.wd_event,
                                        pins_sync[stepper_status_pkg::SY_XBRK],
                                        pins_sync[stepper_status_pkg::SY_YBRK],
                                        2'h0});
        x_bridge_fault_latch = with_check({regs_q.x_latch, 3'h0});
        y_bridge_thermal_latch = with_check({regs_q.y_latch, 2'h0});
        step_position_status = with_check(i_step_position);
    end

    always_comb begin
        unique case (i_reg_addr)
            stepper_status_pkg::ADDR_WDOG: begin
                read_mux = {regs_q.wd_enable, regs_q.wd_time, 3'h0};
            end
            stepper_status_pkg::ADDR_CTRL0: begin
                read_mux = {regs_q.step_mode, regs_q.coil_level};
            end
            stepper_status_pkg::ADDR_LIVE_FAULT: begin
                read_mux = live_fault_status;
            end
            stepper_status_pkg::ADDR_X_LATCH: begin
                read_mux = x_bridge_fault_latch;
            end
            stepper_status_pkg::ADDR_Y_LATCH: begin
                read_mux = y_bridge_thermal_latch;
            end
            stepper_status_pkg::ADDR_STEP_POS: begin
                read_mux = step_position_status;
            end
            default: begin
                // Unmapped and externally held registers answer zero
                read_mux = stepper_status_pkg::REG_RESET;
            end
        endcase
    end

    assign wdog_write = i_reg_wr && (i_reg_addr == stepper_status_pkg::ADDR_WDOG);
    assign wd_clear = wdog_write && !i_reg_wdata[stepper_status_pkg::WATCHDOG_ENABLE_BIT_BIT];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        regs_d = regs_q;
        regs_d.rvalid = i_reg_rd;
        if (i_reg_rd) begin
            regs_d.rdata = read_mux;
            regs_d.rd_addr = i_reg_addr;
        end
        if (wdog_write) begin
            regs_d.wd_enable = i_reg_wdata[stepper_status_pkg::WATCHDOG_ENABLE_BIT_BIT];
            regs_d.wd_time = i_reg_wdata[stepper_status_pkg::WDT_LSB +: stepper_status_pkg::WDT_W];
        end
        if (i_reg_wr && (i_reg_addr == stepper_status_pkg::ADDR_CTRL0)) begin
            regs_d.step_mode = i_reg_wdata[stepper_status_pkg::MODE_LSB +: stepper_status_pkg::MODE_W];
            // No guard on range-crossing decreases; the master owns that hazard
            regs_d.coil_level = i_reg_wdata[stepper_status_pkg::LEVEL_LSB +: stepper_status_pkg::LEVEL_W];
        end
        regs_d.peak_ma = stepper_status_pkg::PEAK_MA_TABLE[regs_q.coil_level];
        // Read-clear of latched images; a new fault in the same cycle wins
        if (i_reg_rd && (i_reg_addr == stepper_status_pkg::ADDR_X_LATCH)) begin
            regs_d.x_latch = '0;
        end
        if (i_reg_rd && (i_reg_addr == stepper_status_pkg::ADDR_Y_LATCH)) begin
            regs_d.y_latch = '0;
        end
        regs_d.x_latch = regs_d.x_latch | x_ovl;
        regs_d.y_latch = regs_d.y_latch | {y_ovl, pins_sync[stepper_status_pkg::SY_TRIP]};
        if (wd_clear) begin
            regs_d.wd_event = 1'b0;
        end
        if (i_watchdog_timeout) begin
            regs_d.wd_event = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            regs_q <= '0;
        end else begin
            regs_q <= regs_d;
        end
    end

    assign o_reg_rdata = regs_q.rdata;
    assign o_reg_rvalid = regs_q.rvalid;
    assign o_coil_peak_level = regs_q.coil_level;
    assign o_peak_coil_amplitude = regs_q.peak_ma;
    assign o_watchdog_enable_bit = regs_q.wd_enable;
    assign o_watchdog_time = regs_q.wd_time;
    assign o_step_mode = regs_q.step_mode;
    assign o_watchdog_event_flag = regs_q.wd_event;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);

    peak_table_a: assert property (
        !$past(i_reset) |-> o_peak_coil_amplitude == stepper_status_pkg::PEAK_MA_TABLE[$past(o_coil_peak_level)]
    ) else $error("Peak amplitude does not follow peak level");

    reset_clear_a: assert property (
        $past(i_reset) |-> (o_reg_rdata == stepper_status_pkg::REG_RESET) && !o_watchdog_event_flag
            && (regs_q.x_latch == '0) && (regs_q.y_latch == '0)
    ) else $error("State not cleared by reset");

    read_check_a: assert property (
        o_reg_rvalid && (regs_q.rd_addr >= stepper_status_pkg::ADDR_LIVE_FAULT)
            && (regs_q.rd_addr <= stepper_status_pkg::ADDR_STEP_POS)
            |-> o_reg_rdata[stepper_status_pkg::CHECK_BIT] == ^o_reg_rdata[stepper_status_pkg::CHECK_BIT-1:0]
    ) else $error("Status check bit wrong");

    live_pump_a: assert property (
        o_reg_rvalid && (regs_q.rd_addr == stepper_status_pkg::ADDR_LIVE_FAULT)
            |-> o_reg_rdata[5] == $past(pins_sync[stepper_status_pkg::SY_PUMP])
    ) else $error("Pump fault not live in status");

    step_live_a: assert property (
        o_reg_rvalid && (regs_q.rd_addr == stepper_status_pkg::ADDR_STEP_POS)
            |-> o_reg_rdata[stepper_status_pkg::POS_W-1:0] == $past(i_step_position)
    ) else $error("Step position not reported");

    wd_set_a: assert property (
        i_watchdog_timeout |=> o_watchdog_event_flag
    ) else $error("Watchdog flag not set on time-out");

    wd_clear_a: assert property (
        wd_clear && !i_watchdog_timeout |=> !o_watchdog_event_flag
    ) else $error("Watchdog flag not cleared by enable write");

    wd_hold_a: assert property (
        o_watchdog_event_flag && !wd_clear |=> o_watchdog_event_flag
    ) else $error("Watchdog flag lost without enable write");

    x_latch_hold_a: assert property (
        regs_q.x_latch[3] && !(i_reg_rd && (i_reg_addr == stepper_status_pkg::ADDR_X_LATCH))
            |=> regs_q.x_latch[3]
    ) else $error("Latched X overload dropped");

    x_ovl_set_a: assert property (
        i_x_pos_high_side_overload [*3] |=> regs_q.x_latch[3]
    ) else $error("X high side overload not latched");

    y_ovl_set_a: assert property (
        i_y_neg_low_side_overload [*3] |=> regs_q.y_latch[1]
    ) else $error("Y low side overload not latched");

    trip_latch_a: assert property (
        pins_sync[stepper_status_pkg::SY_TRIP] |=> regs_q.y_latch[0]
    ) else $error("Thermal trip not latched");

    unmapped_zero_a: assert property (
        o_reg_rvalid && (regs_q.rd_addr > stepper_status_pkg::ADDR_STEP_POS)
            |-> o_reg_rdata == stepper_status_pkg::REG_RESET
    ) else $error("Unmapped read not zero");

    watchdog_enable_bit_write_a: assert property (
        wdog_write |=> o_watchdog_enable_bit == $past(i_reg_wdata[stepper_status_pkg::WATCHDOG_ENABLE_BIT_BIT])
    ) else $error("Watchdog enable not written");

    rvalid_pulse_a: assert property (
        !$past(i_reset) |-> o_reg_rvalid == $past(i_reg_rd)
    ) else $error("Read answer not one cycle after strobe");

    // Writes outside 00h and 01h must leave the watchdog flag, watchdog enable and peak level alone
    status_ro_a: assert property (
        i_reg_wr && (i_reg_addr != stepper_status_pkg::ADDR_WDOG) && (i_reg_addr != stepper_status_pkg::ADDR_CTRL0)
            && !i_watchdog_timeout |=> $stable(o_watchdog_event_flag) && $stable(o_watchdog_enable_bit)
            && $stable(o_coil_peak_level)
    ) else $error("Write to read-only register changed state");

    x_read_clear_a: assert property (
        i_reg_rd && (i_reg_addr == stepper_status_pkg::ADDR_X_LATCH) && (x_ovl == '0) |=> regs_q.x_latch == '0
    ) else $error("X latch not cleared by its read");

    y_read_clear_a: assert property (
        i_reg_rd && (i_reg_addr == stepper_status_pkg::ADDR_Y_LATCH) && (y_ovl == '0)
            && !pins_sync[stepper_status_pkg::SY_TRIP] |=> regs_q.y_latch == '0
    ) else $error("Y latch not cleared by its read");

    x_latch_read_a: assert property (
        o_reg_rvalid && (regs_q.rd_addr == stepper_status_pkg::ADDR_X_LATCH)
            |-> o_reg_rdata[stepper_status_pkg::CHECK_BIT-1 -: stepper_status_pkg::OVL_W] == $past(regs_q.x_latch)
    ) else $error("X latch image wrong");

    y_latch_read_a: assert property (
        o_reg_rvalid && (regs_q.rd_addr == stepper_status_pkg::ADDR_Y_LATCH)
            |-> o_reg_rdata[stepper_status_pkg::CHECK_BIT-1 -: stepper_status_pkg::OVL_W+1] == $past(regs_q.y_latch)
    ) else $error("Y latch image wrong");

    live_flags_a: assert property (
        o_reg_rvalid && (regs_q.rd_addr == stepper_status_pkg::ADDR_LIVE_FAULT)
            |-> o_reg_rdata[stepper_status_pkg::CHECK_BIT-3 -: 3] == $past({regs_q.wd_event,
                pins_sync[stepper_status_pkg::SY_XBRK], pins_sync[stepper_status_pkg::SY_YBRK]})
    ) else $error("Live break or watchdog bit wrong");

    level_write_a: assert property (
        i_reg_wr && (i_reg_addr == stepper_status_pkg::ADDR_CTRL0)
            |=> o_coil_peak_level
                == $past(i_reg_wdata[stepper_status_pkg::LEVEL_LSB +: stepper_status_pkg::LEVEL_W])
    ) else $error("Peak level not written");

endmodule : stepper_driver_status_regs

`default_nettype wire

// ==== verif/serial_master_model.sv ====
// Behavioural serial master that issues register strobes to the status bank
`default_nettype none

module serial_master_model (
    input wire logic i_clk_sys,
    input wire logic i_rvalid,
    input wire logic [7:0] i_rdata,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_addr,
    output logic [7:0] o_wdata
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 8'hFF;
        o_wdata = 8'hFF;
    end

    // ------------------------------
    // Bus cycles
    // ------------------------------
    // Released lines show inverted values, so stale data never matches by luck
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        #1;
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(posedge i_clk_sys);
        #1;
        o_wr = 1'b0;
        o_addr = ~a;
        o_wdata = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        int n;
        n = 0;
        @(posedge i_clk_sys);
        #1;
        o_addr = a;
        o_rd = 1'b1;
        @(posedge i_clk_sys);
        #1;
        o_rd = 1'b0;
        o_addr = ~a;
        while (i_rvalid !== 1'b1 && n < 3) begin
            @(posedge i_clk_sys);
            #1;
            n++;
        end
        d = i_rdata;
        ok = i_rvalid;
    endtask : rd

endmodule : serial_master_model

`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the stepper driver status bank
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic i_clk_sys = 1'b0;
    logic i_reset = 1'b1;
    logic i_watchdog_timeout = 1'b0;
    logic [6:0] i_step_position = 7'h00;
    logic [12:0] flt = 13'h0000;
    logic [12:0] h;
    logic i_reg_wr, i_reg_rd, o_reg_rvalid, o_watchdog_enable_bit, o_watchdog_event_flag;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
    logic [4:0] o_coil_peak_level;
    logic [2:0] o_step_mode, m;
    logic [11:0] o_peak_coil_amplitude;
    logic [3:0] o_watchdog_time;
    int fails = 0;
    int samples_checked = 0;
    int ma[32] = '{66, 135, 189, 200, 221, 244, 269, 297, 328, 366, 400, 442, 488, 538, 594, 654,
                   735, 800, 883, 975, 1077, 1189, 1255, 1485, 1625, 1767, 1950, 2153, 2378, 2552, 2775, 3015};

    always #2.5 i_clk_sys = ~i_clk_sys;

    stepper_driver_status_regs u_dut (
        .i_clk_sys, .i_reset, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
        .i_thermal_alert(flt[0]), .i_pump_fault(flt[1]), .i_coil_x_break(flt[2]), .i_coil_y_break(flt[3]),
        .i_thermal_trip(flt[4]), .i_x_pos_high_side_overload(flt[5]), .i_x_pos_low_side_overload(flt[6]),
        .i_x_neg_high_side_overload(flt[7]), .i_x_neg_low_side_overload(flt[8]),
        .i_y_pos_high_side_overload(flt[9]), .i_y_pos_low_side_overload(flt[10]),
        .i_y_neg_high_side_overload(flt[11]), .i_y_neg_low_side_overload(flt[12]),
        .i_watchdog_timeout, .i_step_position, .o_reg_rdata, .o_reg_rvalid, .o_coil_peak_level,
        .o_peak_coil_amplitude, .o_watchdog_enable_bit, .o_watchdog_time, .o_step_mode, .o_watchdog_event_flag
    );

    serial_master_model u_host (
        .i_clk_sys, .i_rvalid(o_reg_rvalid), .i_rdata(o_reg_rdata),
        .o_wr(i_reg_wr), .o_rd(i_reg_rd), .o_addr(i_reg_addr), .o_wdata(i_reg_wdata)
    );

    // ------------------------------
    // Helpers
    // ------------------------------
    function automatic logic [7:0] img(input logic [6:0] p);
        return {^p, p};
    endfunction : img

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask : wait_cyc

    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Bounded wait for the read answer; a missing answer ends the run
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        logic ok;
        u_host.rd(a, v, ok);
        if (ok !== 1'b1) begin
            fails++;
            $display("BAD read answer at %h expected 1 seen 0", a);
            conclude();
        end else begin
            chk($sformatf("read %h", a), {4'h0, exp}, {4'h0, v});
        end
    endtask : rd_chk

    task automatic all_zero();
        chk("wd flag", 12'h000, {11'h0, o_watchdog_event_flag});
        for (int a = 0; a < 9; a++) begin
            rd_chk(8'(a), 8'h00);
        end
    endtask : all_zero

    // ------------------------------
    // Main sequence
    // ------------------------------
    initial begin
        void'($urandom(10));
        wait_cyc(2);
        i_reset = 1'b0;
        all_zero();
        // Rising order only: lowering across current ranges may trip overload
        for (int i = 0; i < 32; i++) begin
            m = 3'($urandom_range(6));
            u_host.wr(8'h01, {m, 5'(i)});
            wait_cyc(1);
            chk("peak level", 12'(i), {7'h0, o_coil_peak_level});
            chk("step mode", {9'h0, m}, {9'h0, o_step_mode});
            chk("amplitude", 12'(ma[i]), o_peak_coil_amplitude);
            rd_chk(8'h01, {m, 5'(i)});
        end
        for (int i = 0; i < 12; i++) begin
            flt[3:0] = 4'($urandom);
            i_step_position = 7'($urandom);
            wait_cyc(5);
            rd_chk(8'h04, img({flt[0], flt[1], 1'b0, flt[2], flt[3], 2'b00}));
            rd_chk(8'h07, img(i_step_position));
        end
        flt = 13'h0000;
        for (int k = 4; k < 14; k++) begin
            h = (k < 13) ? (13'h0001 << k) : {9'($urandom), 4'h0};
            flt = h;
            wait_cyc(5);
            flt = 13'h0000;
            wait_cyc(5);
            rd_chk(8'h05, img({h[5], h[6], h[7], h[8], 3'b000}));
            rd_chk(8'h06, img({h[9], h[10], h[11], h[12], h[4], 2'b00}));
            rd_chk(8'h05, 8'h00);
            rd_chk(8'h06, 8'h00);
        end
        i_watchdog_timeout = 1'b1;
        wait_cyc(1);
        i_watchdog_timeout = 1'b0;
        wait_cyc(1);
        chk("wd flag", 12'h001, {11'h0, o_watchdog_event_flag});
        rd_chk(8'h04, img(7'h10));
        rd_chk(8'h04, img(7'h10));
        u_host.wr(8'h04, 8'hFF);
        u_host.wr(8'h00, 8'hA8);
        wait_cyc(1);
        chk("wd enable", 12'h001, {11'h0, o_watchdog_enable_bit});
        chk("wd time", 12'h005, {8'h0, o_watchdog_time});
        rd_chk(8'h00, 8'hA8);
        rd_chk(8'h04, img(7'h10));
        u_host.wr(8'h00, 8'h28);
        wait_cyc(1);
        chk("wd flag", 12'h000, {11'h0, o_watchdog_event_flag});
        rd_chk(8'h04, 8'h00);
        // Second reset with flags set and a raised level
        i_watchdog_timeout = 1'b1;
        flt[5] = 1'b1;
        wait_cyc(5);
        i_watchdog_timeout = 1'b0;
        flt[5] = 1'b0;
        i_step_position = 7'h00;
        i_reset = 1'b1;
        wait_cyc(2);
        i_reset = 1'b0;
        chk("peak level", 12'h000, {7'h0, o_coil_peak_level});
        all_zero();
        conclude();
    end

endmodule : tb_top

`default_nettype wire
